// *** core/mcu_host_bus_emulation.sv ***
// Bus master that emulates a microcontroller external bus toward a peripheral.
// Assumes commands from logic on ref_clk; bus_wait_n and aux pins are async pins.
//
// Overview of operation
// - Low wait input stretches the strobe phase until it returns high.
// - A divide-by-two replica of the working clock is presented on the clock monitor output.
// - Address bits 8 to 15 are driven on eight upper-address outputs.
// - Chip select is a low pulse covering each read or write access.
// - Address latch strobe pulses high so the peripheral captures the address.
// - Active-low read strobe fetches data; active-low write strobe delivers it.
// - Write data is valid before write strobe falls and held after it rises.
// - Wait commands stall until the auxiliary pin is high, or until low.
// - After the awaited level, the queued read runs and its value returns.
`timescale 1ns/1ps

module mcu_host_bus_emulation
(
   input  wire logic        ref_clk,
   input  wire logic        nrst,
   input  wire logic        cmd_valid,
   input  wire logic [2:0]  cmd_op,
   input  wire logic [15:0] cmd_addr,
   input  wire logic [7:0]  cmd_wdata,
   output logic             cmd_ready,
   output logic             rsp_valid,
   output logic [7:0]       rsp_data,
   input  wire logic        bus_wait_n,
   input  wire logic        aux_pin_zero,
   input  wire logic [7:0]  ad_in,
   output logic [7:0]       ad_out,
   output logic             ad_oe,
   output logic [7:0]       upper_addr,
   output logic             ale,
   output logic             cs_n,
   output logic             rd_n,
   output logic             wr_n,
   output logic             clock_monitor_out
);

   // ----------------------------------------------------------------
   // State record
   // ----------------------------------------------------------------
   typedef struct packed
   {
      host_bus_pkg::bus_state_t st;
      logic [3:0]  cnt;
      logic        is_write;
      logic        want_high;
      logic [7:0]  wdata;
      logic [7:0]  lo_addr;
      logic [1:0]  wait_sync;
      logic [1:0]  aux_sync;
      logic [7:0]  ad_meta;
      logic [7:0]  ad_sync;
      logic [7:0]  rd_data;
      logic        cmd_ready;
      logic        rsp_valid;
      logic [7:0]  rsp_data;
      logic [7:0]  ad_out;
      logic        ad_oe;
      logic [7:0]  upper_addr;
      logic        ale;
      logic        cs_n;
      logic        rd_n;
      logic        wr_n;
      logic        clk_mon;
   } state_t;

   state_t s_r;
   state_t s_nxt;

   // Outputs straight from the state flops
   assign cmd_ready         = s_r.cmd_ready;
   assign rsp_valid         = s_r.rsp_valid;
   assign rsp_data          = s_r.rsp_data;
   assign ad_out            = s_r.ad_out;
   assign ad_oe             = s_r.ad_oe;
   assign upper_addr        = s_r.upper_addr;
   assign ale               = s_r.ale;
   assign cs_n              = s_r.cs_n;
   assign rd_n              = s_r.rd_n;
   assign wr_n              = s_r.wr_n;
   assign clock_monitor_out = s_r.clk_mon;

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   always_comb
   begin
      s_nxt           = s_r;
      s_nxt.rsp_valid = 1'b0;
      s_nxt.ale       = 1'b0;
      // Synchronise the asynchronous pins
      s_nxt.wait_sync = {s_r.wait_sync[0], bus_wait_n};
      s_nxt.aux_sync  = {s_r.aux_sync[0], aux_pin_zero};
      // Low data pins pass two flops like the other pins
      s_nxt.ad_meta   = ad_in;
      s_nxt.ad_sync   = s_r.ad_meta;
      // Divide-by-two replica of the working clock
      s_nxt.clk_mon   = ~s_r.clk_mon;
      if (s_r.cnt != 4'h0)
      begin
         s_nxt.cnt = s_r.cnt - 4'h1;
      end
      unique case (s_r.st)
         host_bus_pkg::ST_IDLE:
         begin
            if (cmd_valid && s_r.cmd_ready)
            begin
               s_nxt.cmd_ready  = 1'b0;
               s_nxt.upper_addr = cmd_addr[15:8];
               s_nxt.lo_addr    = cmd_addr[7:0];
               s_nxt.wdata      = cmd_wdata;
               s_nxt.is_write   = (cmd_op == host_bus_pkg::CMD_WRITE);
               s_nxt.want_high  = (cmd_op == host_bus_pkg::CMD_WAIT_HIGH);
               if (cmd_op == host_bus_pkg::CMD_WAIT_HIGH || cmd_op == host_bus_pkg::CMD_WAIT_LOW)
               begin
                  s_nxt.st = host_bus_pkg::ST_WAITIRQ;
               end
               else
               begin
                  s_nxt.st     = host_bus_pkg::ST_LATCH;
                  s_nxt.ad_out = cmd_addr[7:0];
                  s_nxt.ad_oe  = 1'b1;
                  s_nxt.ale    = 1'b1;
                  s_nxt.cnt    = host_bus_pkg::PHASE_CYC;
               end
            end
         end
         host_bus_pkg::ST_WAITIRQ:
         begin
            // Stall until the awaited level, then perform the queued read
            if (s_r.aux_sync[1] == s_r.want_high)
            begin
               s_nxt.st     = host_bus_pkg::ST_LATCH;
               s_nxt.ad_out = s_r.lo_addr;
               s_nxt.ad_oe  = 1'b1;
               s_nxt.ale    = 1'b1;
               s_nxt.cnt    = host_bus_pkg::PHASE_CYC;
            end
         end
         host_bus_pkg::ST_LATCH:
         begin
            s_nxt.ale = (s_r.cnt != 4'h1) && (s_r.cnt != 4'h0);
            if (s_r.cnt == 4'h0)
            begin
               // Select asserted; write data set up before write strobe
               s_nxt.st     = host_bus_pkg::ST_SETUP;
               s_nxt.cs_n   = 1'b0;
               s_nxt.ad_out = s_r.wdata;
               s_nxt.ad_oe  = s_r.is_write;
               s_nxt.cnt    = host_bus_pkg::PHASE_CYC;
            end
         end
         host_bus_pkg::ST_SETUP:
         begin
            if (s_r.cnt == 4'h0)
            begin
               s_nxt.st   = host_bus_pkg::ST_STROBE;
               s_nxt.rd_n = s_r.is_write;
               s_nxt.wr_n = ~s_r.is_write;
               s_nxt.cnt  = host_bus_pkg::PHASE_CYC;
            end
         end
         host_bus_pkg::ST_STROBE:
         begin
            // Hold the strobe while the peripheral pulls wait low
            if (s_r.cnt == 4'h0 && s_r.wait_sync[1])
            begin
               s_nxt.st      = host_bus_pkg::ST_HOLD;
               s_nxt.rd_n    = 1'b1;
               s_nxt.wr_n    = 1'b1;
               s_nxt.cnt     = host_bus_pkg::PHASE_CYC;
            end
         end
         host_bus_pkg::ST_HOLD:
         begin
            // The synchronised copy lags two edges, so on the first hold
            // cycle it still shows the pins as they stood under the strobe
            if (s_r.cnt == host_bus_pkg::PHASE_CYC)
            begin
               s_nxt.rd_data = s_r.ad_sync;
            end
            // Data stays driven after the write strobe rises
            if (s_r.cnt == 4'h0)
            begin
               s_nxt.st        = host_bus_pkg::ST_IDLE;
               s_nxt.cs_n      = 1'b1;
               s_nxt.ad_oe     = 1'b0;
               s_nxt.cmd_ready = 1'b1;
               s_nxt.rsp_valid = ~s_r.is_write;
               s_nxt.rsp_data  = s_r.rd_data;
            end
         end
         default:
         begin
            s_nxt.st = host_bus_pkg::ST_IDLE;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         s_r            <= '0;
         s_r.st         <= host_bus_pkg::ST_IDLE;
         s_r.wait_sync  <= 2'b11;
         s_r.cmd_ready  <= 1'b1;
         s_r.cs_n       <= 1'b1;
         s_r.rd_n       <= 1'b1;
         s_r.wr_n       <= 1'b1;
         s_r.upper_addr <= host_bus_pkg::ADDR_RST;
         s_r.ad_out     <= host_bus_pkg::DATA_RST;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

endmodule

// *** dv/host_bus_chk_asserts.sv ***
// Port checker for the emulated bus master.
// Assumes binding into mcu_host_bus_emulation, one clock domain.
`timescale 1ns/1ps
module host_bus_chk
(
   input wire logic        ref_clk,
   input wire logic        nrst,
   input wire logic        cmd_valid,
   input wire logic        cmd_ready,
   input wire logic [15:0] cmd_addr,
   input wire logic        rsp_valid,
   input wire logic        bus_wait_n,
   input wire logic [7:0]  ad_out,
   input wire logic        ad_oe,
   input wire logic [7:0]  upper_addr,
   input wire logic        ale,
   input wire logic        cs_n,
   input wire logic        rd_n,
   input wire logic        wr_n,
   input wire logic        clock_monitor_out
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   logic [15:0] taken_r;
   // Address of the last accepted command
   always_ff @(posedge ref_clk or negedge nrst)
      if (!nrst)
         taken_r <= 16'h0000;
      else if (cmd_valid && cmd_ready)
         taken_r <= cmd_addr;
   a_mon_toggle: assert property (1'b1 |=> $changed(clock_monitor_out))
      else $error("clock monitor stalled");
   a_addr_phase: assert property (ale |-> ad_oe && {upper_addr, ad_out} == taken_r)
      else $error("wrong address during latch");
   a_latch_first: assert property ($fell(cs_n) |-> $past(ale, 2) && !ale)
      else $error("select without latch pulse");
   a_strobe_select: assert property ((!rd_n || !wr_n) |-> !cs_n && (rd_n || wr_n))
      else $error("strobe outside select");
   a_write_hold: assert property ((!wr_n || $rose(wr_n)) |-> ad_oe && $past(ad_oe) && $stable(ad_out))
      else $error("write data moved");
   a_read_float: assert property (!rd_n |-> !ad_oe)
      else $error("bus driven while reading");
   a_rsp_end: assert property (rsp_valid |-> $rose(cs_n) && cmd_ready)
      else $error("response not at end of access");
   a_wait_hold: assert property ((!rd_n && !bus_wait_n) [*4] |=> !rd_n)
      else $error("strobe released during wait");
   a_select_len: assert property ($fell(cs_n) |-> !cs_n [*8])
      else $error("select pulse too short");
   a_busy_select: assert property (!cs_n |-> !cmd_ready)
      else $error("ready during access");
endmodule
bind mcu_host_bus_emulation host_bus_chk host_bus_chk_inst (.*);

// *** dv/periph_model.sv ***
// Peripheral on the emulated bus: byte memory, optional wait stretching.
// Assumes the bench sets slow between commands.
`timescale 1ns/1ps
module periph_model
(
   input  wire logic        ref_clk,
   input  wire logic        ale,
   input  wire logic        cs_n,
   input  wire logic        rd_n,
   input  wire logic        wr_n,
   input  wire logic [7:0]  upper_addr,
   input  wire logic [7:0]  ad_out,
   input  wire logic        slow,
   output logic [7:0]       ad_in,
   output logic             bus_wait_n,
   output logic [15:0]      last_addr
);
   logic [7:0] mem [256];
   int         held = 0;
   initial ad_in = 8'h00;
   initial bus_wait_n = 1'b1;
   initial last_addr = 16'h0000;
   // Latch address, store writes, answer reads, stretch strobes
   always @(posedge ref_clk)
   begin
      if (ale)
         last_addr <= {upper_addr, ad_out};
      if (!cs_n && !wr_n)
         mem[last_addr[7:0]] <= ad_out;
      ad_in <= (!cs_n && !rd_n) ? mem[last_addr[7:0]] : ~ad_in;
      // Wait goes low from the start of select, ahead of the strobe, so the
      // master's two-flop sampling of it sees it before the strobe would end
      held <= !cs_n ? held + 1 : 0;
      bus_wait_n <= !(slow && !cs_n && held < 12);
   end
endmodule

// *** dv/testbench.sv ***
// Self-checking bench for the emulated bus master.
// Assumes periph_model on the bus side.
`timescale 1ns/1ps
module testbench;
   logic        ref_clk = 0;
   logic        nrst = 0;
   logic        cmd_valid = 0;
   logic [2:0]  cmd_op = 3'h0;
   logic [15:0] cmd_addr = 16'h0000;
   logic [7:0]  cmd_wdata = 8'h00;
   logic        aux = 0;
   logic        slow = 0;
   logic        cmd_ready, rsp_valid, bus_wait_n, ad_oe, ale, cs_n, rd_n, wr_n, mon;
   logic [7:0]  rsp_data, ad_in, ad_out, upper_addr;
   logic [15:0] last_addr;
   int          fails = 0, checked = 0, ticks = 0, rsps = 0, cyc, base;
   always #25 ref_clk = ~ref_clk;
   mcu_host_bus_emulation mcu_host_bus_emulation_inst (.ref_clk(ref_clk), .nrst(nrst),
      .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
      .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .bus_wait_n(bus_wait_n),
      .aux_pin_zero(aux), .ad_in(ad_in), .ad_out(ad_out), .ad_oe(ad_oe), .upper_addr(upper_addr),
      .ale(ale), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .clock_monitor_out(mon));
   periph_model periph_model_inst (.ref_clk(ref_clk), .ale(ale), .cs_n(cs_n), .rd_n(rd_n),
      .wr_n(wr_n), .upper_addr(upper_addr), .ad_out(ad_out), .slow(slow), .ad_in(ad_in),
      .bus_wait_n(bus_wait_n), .last_addr(last_addr));
   // Count responses where outputs are settled and cut a hang short
   always @(negedge ref_clk)
   begin
      rsps += (rsp_valid === 1'b1);
      ticks++;
      if (ticks == 3000)
      begin
         fails++;
         final_report();
      end
   end
   task automatic final_report();
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp)
      begin
         fails++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One command; stall holds the aux level off for a while first
   task automatic issue(input logic [2:0] op, input logic [15:0] a, input logic [7:0] d, input bit stall);
      int n;
      n = rsps;
      @(negedge ref_clk);
      {cmd_valid, cmd_op, cmd_addr, cmd_wdata} = {1'b1, op, a, d};
      @(negedge ref_clk);
      cmd_valid = 0;
      if (stall)
      begin
         repeat (30) @(negedge ref_clk);
         check({cs_n, 15'h0000} | 16'(rsps - n), 16'h8000);
         aux = ~aux;
      end
      cyc = 0;
      @(negedge ref_clk);
      while (cmd_ready !== 1'b1 && cyc < 200)
      begin
         @(negedge ref_clk);
         cyc++;
      end
      // One more cycle so the response pulse has been counted
      @(negedge ref_clk);
      check(16'(rsps - n), 16'(op != host_bus_pkg::CMD_WRITE));
   endtask
   task automatic t_rw();
      issue(host_bus_pkg::CMD_WRITE, 16'h12a5, 8'h3c, 0);
      check(last_addr, 16'h12a5);
      check(upper_addr, 16'h0012);
      issue(host_bus_pkg::CMD_READ, 16'h12a5, 8'h00, 0);
      base = cyc;
      check(rsp_data, 16'h003c);
      $display("test rw done");
   endtask
   task automatic t_wait();
      slow = 1;
      issue(host_bus_pkg::CMD_WRITE, 16'hf0a6, 8'h96, 0);
      issue(host_bus_pkg::CMD_READ, 16'hf0a6, 8'h00, 0);
      check(16'(cyc > base + 4), 16'h0001);
      check(rsp_data, 16'h0096);
      slow = 0;
      $display("test wait done");
   endtask
   task automatic t_aux();
      aux = 1;
      issue(host_bus_pkg::CMD_WAIT_LOW, 16'h07a5, 8'h00, 1);
      check(rsp_data, 16'h003c);
      issue(host_bus_pkg::CMD_WAIT_HIGH, 16'h55a6, 8'h00, 1);
      check(rsp_data, 16'h0096);
      check(upper_addr, 16'h0055);
      $display("test aux done");
   endtask
   task automatic t_clk();
      logic m;
      @(negedge ref_clk);
      m = mon;
      @(negedge ref_clk);
      check(mon, 16'(!m));
      $display("test clock done");
   endtask
   initial
   begin
      repeat (6) @(negedge ref_clk);
      nrst = 1;
      t_clk();
      t_rw();
      t_wait();
      t_aux();
      final_report();
   end
endmodule

// *** shared/host_bus_pkg.sv ***
// Constants and types for the emulated microcontroller bus master.
// Assumes a single 20 MHz clock domain; no software-visible registers.
package host_bus_pkg;

   // ----------------------------------------------------------------
   // Command codes presented on the command port
   // ----------------------------------------------------------------
   localparam logic [2:0] CMD_READ        = 3'h0;
   localparam logic [2:0] CMD_WRITE       = 3'h1;
   localparam logic [2:0] CMD_WAIT_HIGH   = 3'h2;
   localparam logic [2:0] CMD_WAIT_LOW    = 3'h3;

   // ----------------------------------------------------------------
   // Timing: each strobe phase lasts at least this long
   // ----------------------------------------------------------------
   localparam int         CLK_PERIOD_NS   = 50;
   localparam int         PHASE_NS        = 100;
   localparam int         PHASE_CYC_INT   = (PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] PHASE_CYC       = 4'(PHASE_CYC_INT);

   // ----------------------------------------------------------------
   // Reset values of the bus pins
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_RST        = 8'h00;
   localparam logic [7:0] DATA_RST        = 8'h00;

   // ----------------------------------------------------------------
   // Bus sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [2:0]
   {
      ST_IDLE   = 3'b000,
      ST_WAITIRQ= 3'b001,
      ST_LATCH  = 3'b010,
      ST_SETUP  = 3'b011,
      ST_STROBE = 3'b100,
      ST_HOLD   = 3'b101
   } bus_state_t;

endpackage
